// *** rtl/sbsr_pkg.sv ***
// Package: register map, field layout, timing constants and carrier types of the baud block
// ****************************************************************************
// Overview of operation
// - Double-buffer bit enables transmit buffering, and receive buffering with internal serial clock.
// - Receive buffering stays on in UART mode and with external serial clock.
// - Writing reset code 10 as second write of the sequence starts a soft reset.
// - Soft reset clears both enables, buffer and transmit flags, and error flags.
// - Transmitting flag reads 1 during a transmission and 0 once stopped.
// - Soft reset takes effect two clocks after the reset write is recognised.
// - Fraction enable selects divide by N plus (16-K)/16 in UART mode; clear, or outside UART mode, gives N only.
// - Two-bit source field picks prescaler tap divide-by 1, 4, 16 or 64.
// - Four-bit divisor N: codes 1 to 15 literal, code 0 means 16.
// - Four-bit K for fractional division: 1 to 15, code 0 prohibited.
// ****************************************************************************
package sbsr_pkg;

  // Byte offsets on the register bus
  localparam logic [7:0] SBSR_OFS_CHAN = 8'h00;
  localparam logic [7:0] SBSR_OFS_MODE2 = 8'h04;
  localparam logic [7:0] SBSR_OFS_ERR = 8'h08;
  localparam logic [7:0] SBSR_OFS_BRCR = 8'h0c;
  localparam logic [7:0] SBSR_OFS_BRADD = 8'h10;
  localparam logic [7:0] SBSR_OFS_IST = 8'h14;
  localparam logic [7:0] SBSR_OFS_ICLR = 8'h18;
  localparam logic [7:0] SBSR_OFS_IEN = 8'h1c;

  // Field positions
  localparam int SBSR_CHAN_RXE = 0;
  localparam int SBSR_CHAN_TXE = 1;
  localparam int SBSR_CHAN_UART = 2;
  localparam int SBSR_CHAN_SCLKIN = 3;
  localparam int SBSR_M2_WBUF = 2;
  localparam int SBSR_M2_TXRUN = 5;
  localparam int SBSR_M2_RX_BUFFER_FULL_FLAG = 6;
  localparam int SBSR_M2_TBEMP = 7;
  localparam int SBSR_BR_FRAC = 6;

  // Soft reset codes and delay
  localparam logic [1:0] SBSR_SRST_ARM = 2'h1;
  localparam logic [1:0] SBSR_SRST_FIRE = 2'h2;
  localparam int SBSR_SRST_DELAY = 2;

  // Reset values
  localparam logic [7:0] SBSR_BRCR_RST = 8'h00;
  localparam logic [3:0] SBSR_BRK_RST = 4'h0;

  // Prescaler taps and divisor constants
  localparam int SBSR_NTAPS = 4;
  localparam int SBSR_PRE_W = 6;
  localparam logic [4:0] SBSR_FRAC_DEN = 5'h10;

  // Interrupt events
  localparam int SBSR_NEVT = 4;
  localparam int SBSR_EVT_SRST = 0;
  localparam int SBSR_EVT_OVERRUN_ERROR_FLAG = 1;
  localparam int SBSR_EVT_PARITY_ERROR_FLAG = 2;
  localparam int SBSR_EVT_FRAMING_ERROR_FLAG = 3;

  typedef enum logic [1:0] {SBSR_SR_IDLE = 2'b01, SBSR_SR_ARMED = 2'b10} sbsr_sr_t;

  // Events from the shift-register datapath, same clock
  typedef struct packed {
    logic tx_load;
    logic tx_take;
    logic tx_active;
    logic rx_done;
    logic rx_read;
    logic overrun;
    logic parity;
    logic framing;
  } sbsr_dp_evt_t;

  // Configuration driven to the datapath
  typedef struct packed {
    logic rx_enable;
    logic tx_enable;
    logic tx_dbuf_en;
    logic rx_dbuf_en;
    logic uart_mode;
    logic sclk_input;
    logic chan_reset;
  } sbsr_cfg_t;

  typedef struct packed {
    logic [SBSR_PRE_W-1:0] cnt;
    logic [SBSR_NTAPS-1:0] taps;
  } sbsr_pre_state_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic [3:0] acc;
    logic extra;
    logic tick;
  } sbsr_bg_state_t;

  typedef struct packed {
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_done;
    logic [31:0] rdata;
    logic rx_en;
    logic tx_en;
    logic uart_mode;
    logic sclk_in;
    logic wbuf;
    logic [1:0] srst_code;
    sbsr_sr_t sr;
    logic [SBSR_SRST_DELAY-1:0] srst_pipe;
    logic tbemp;
    logic rx_buffer_full_flag;
    logic txrun;
    logic overrun_error_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic [7:0] brcr;
    logic [3:0] brk;
    logic [SBSR_NEVT-1:0] ist;
    logic [SBSR_NEVT-1:0] ien;
  } sbsr_top_state_t;

endpackage

// *** rtl/sbsr_prescaler.sv ***
// Prescaler: free-running counter giving one-cycle tap pulses at divide-by 1, 4, 16 and 64
`timescale 1ns/1ps
module sbsr_prescaler import sbsr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  output logic [SBSR_NTAPS-1:0] taps
);
  sbsr_pre_state_t s_reg;
  sbsr_pre_state_t s_next;
  logic [SBSR_NTAPS-1:0] hit;

  // Tap i fires when the low 2*i counter bits are all ones
  assign hit[0] = 1'b1;
  for (genvar i = 1; i < SBSR_NTAPS; i++) begin : g_tap
    assign hit[i] = &s_reg.cnt[2*i-1:0];
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.cnt = s_reg.cnt + 1'b1;
    s_next.taps = hit;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign taps = s_reg.taps;
endmodule // sbsr_prescaler

// *** rtl/sbsr_baud_gen.sv ***
// Baud generator: divides the selected tap by N, or by N + (16 - K)/16
`timescale 1ns/1ps
module sbsr_baud_gen import sbsr_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SBSR_NTAPS-1:0] taps,
  input wire logic [1:0] tap_sel,
  input wire logic [3:0] n_code,
  input wire logic [3:0] k_code,
  input wire logic frac_en,
  output logic tick
);
  sbsr_bg_state_t s_reg;
  sbsr_bg_state_t s_next;
  logic tap;
  logic [4:0] n_eff;
  logic [4:0] last;
  logic [4:0] sum;

  assign tap = taps[tap_sel];
  assign n_eff = (n_code == 4'h0) ? 5'h10 : {1'b0, n_code};
  assign last = n_eff - 5'h1 + {4'h0, s_reg.extra};
  // Accumulate 16-K per period; a carry stretches the next period by one tap
  assign sum = {1'b0, s_reg.acc} + (SBSR_FRAC_DEN - {1'b0, k_code});

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (tap) begin
      if (s_reg.cnt >= last) begin
        s_next.tick = 1'b1;
        s_next.cnt = '0;
        s_next.acc = frac_en ? sum[3:0] : 4'h0;
        s_next.extra = frac_en & sum[4];
      end else begin
        s_next.cnt = s_reg.cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

  // Helper: taps counted per period, and whether settings moved meanwhile
  logic [5:0] h_taps;
  logic h_chg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h_taps <= '0;
      h_chg <= 1'b1;
    end else begin
      h_taps <= (s_reg.tick ? 6'h0 : h_taps) + {5'h0, tap};
      h_chg <= (s_reg.tick ? 1'b0 : h_chg) | !$stable(n_code) | !$stable(tap_sel)
        | !$stable(frac_en) | !$stable(k_code);
    end
  end

  int_div_a: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.tick && !h_chg && !frac_en |-> h_taps == {1'b0, n_eff})
    else $error("integer period differs from N");
  frac_div_a: assert property (@(posedge clk) disable iff (!nrst)
    s_reg.tick && !h_chg && frac_en |-> h_taps == {1'b0, n_eff} || h_taps == {1'b0, n_eff} + 6'h1)
    else $error("fractional period not N or N+1");
  frac_long_c: cover property (@(posedge clk) disable iff (!nrst)
    s_reg.tick && frac_en && h_taps == {1'b0, n_eff} + 6'h1);
endmodule // sbsr_baud_gen

// *** rtl/sbsr_top.sv ***
// Top: bus slave, double-buffer control, soft reset sequencer, flags, interrupt, baud clock
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sbsr_top import sbsr_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire sbsr_dp_evt_t dp_evt,
  output sbsr_cfg_t cfg,
  output logic baud_tick,
  output logic irq
);

  // ****************************************************************************
  // Elaboration checks
  // ****************************************************************************
  if (ADDR_W != 8) begin : g_bad_addr
    $error("sbsr_top: decode serves an 8-bit register window only");
  end

  // ****************************************************************************
  // State
  // ****************************************************************************
  sbsr_top_state_t s_reg;
  sbsr_top_state_t s_next;
  logic addr_take;
  logic wr;
  logic rd;
  logic srst_start;
  logic srst_apply;
  logic [31:0] rd_mux;
  logic [SBSR_NEVT-1:0] evt;
  logic [SBSR_NTAPS-1:0] taps;

  // Address phase is taken only while the bus is ready
  assign addr_take = hsel && hready && htrans[1];
  assign wr = s_reg.dp_valid && s_reg.dp_write;
  assign rd = s_reg.dp_valid && !s_reg.dp_write && !s_reg.rd_done;
  // Last stage of the delay line performs the reset
  assign srst_apply = s_reg.srst_pipe[SBSR_SRST_DELAY-1];

  // Events that raise sticky interrupt status
  assign evt[SBSR_EVT_SRST] = srst_apply;
  assign evt[SBSR_EVT_OVERRUN_ERROR_FLAG] = dp_evt.overrun;
  assign evt[SBSR_EVT_PARITY_ERROR_FLAG] = dp_evt.parity;
  assign evt[SBSR_EVT_FRAMING_ERROR_FLAG] = dp_evt.framing;

  // ****************************************************************************
  // Read multiplexer
  // ****************************************************************************
  // Unmapped offsets and write-only clear read as zero
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_reg.dp_addr)
      SBSR_OFS_CHAN: begin
        rd_mux[SBSR_CHAN_RXE] = s_reg.rx_en;
        rd_mux[SBSR_CHAN_TXE] = s_reg.tx_en;
        rd_mux[SBSR_CHAN_UART] = s_reg.uart_mode;
        rd_mux[SBSR_CHAN_SCLKIN] = s_reg.sclk_in;
      end
      SBSR_OFS_MODE2: begin
        rd_mux[1:0] = s_reg.srst_code;
        rd_mux[SBSR_M2_WBUF] = s_reg.wbuf;
        rd_mux[SBSR_M2_TXRUN] = s_reg.txrun;
        rd_mux[SBSR_M2_RX_BUFFER_FULL_FLAG] = s_reg.rx_buffer_full_flag;
        rd_mux[SBSR_M2_TBEMP] = s_reg.tbemp;
      end
      SBSR_OFS_ERR: rd_mux[2:0] = {s_reg.framing_error_flag, s_reg.parity_error_flag, s_reg.overrun_error_flag};
      SBSR_OFS_BRCR: rd_mux[7:0] = s_reg.brcr;
      SBSR_OFS_BRADD: rd_mux[3:0] = s_reg.brk;
      SBSR_OFS_IST: rd_mux[SBSR_NEVT-1:0] = s_reg.ist;
      SBSR_OFS_IEN: rd_mux[SBSR_NEVT-1:0] = s_reg.ien;
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************************************************
  // Next-state logic
  // ****************************************************************************
  always_comb begin
    s_next = s_reg;
    srst_start = 1'b0;

    // Bus phases: a read holds one wait state so read data leave a flop
    if (addr_take) begin
      s_next.dp_valid = 1'b1;
      s_next.dp_write = hwrite;
      s_next.dp_addr = haddr[7:0];
      s_next.rd_done = 1'b0;
    end else if (hready) begin
      s_next.dp_valid = 1'b0;
    end
    if (rd) begin
      s_next.rdata = rd_mux;
      s_next.rd_done = 1'b1;
    end

    // Register writes
    if (wr) begin
      unique case (s_reg.dp_addr)
        SBSR_OFS_CHAN: begin
          s_next.rx_en = hwdata[SBSR_CHAN_RXE];
          s_next.tx_en = hwdata[SBSR_CHAN_TXE];
          s_next.uart_mode = hwdata[SBSR_CHAN_UART];
          s_next.sclk_in = hwdata[SBSR_CHAN_SCLKIN];
        end
        SBSR_OFS_MODE2: begin
          s_next.wbuf = hwdata[SBSR_M2_WBUF];
          s_next.srst_code = hwdata[1:0];
          // A fire code counts only straight after an arm code
          if (hwdata[1:0] == SBSR_SRST_ARM) begin
            s_next.sr = SBSR_SR_ARMED;
          end else begin
            s_next.sr = SBSR_SR_IDLE;
            srst_start = (hwdata[1:0] == SBSR_SRST_FIRE) && (s_reg.sr == SBSR_SR_ARMED);
          end
        end
        SBSR_OFS_BRCR: s_next.brcr = hwdata[7:0];
        SBSR_OFS_BRADD: s_next.brk = hwdata[3:0];
        SBSR_OFS_ICLR: s_next.ist = s_reg.ist & ~hwdata[SBSR_NEVT-1:0];
        SBSR_OFS_IEN: s_next.ien = hwdata[SBSR_NEVT-1:0];
        default: s_next.sr = s_reg.sr;
      endcase
    end

    // Two-stage delay between recognition and the reset itself
    s_next.srst_pipe = {s_reg.srst_pipe[SBSR_SRST_DELAY-2:0], srst_start};

    // Buffer flags: set wins over clear in the same cycle
    if (dp_evt.tx_load) begin
      s_next.tbemp = 1'b0;
    end
    if (dp_evt.tx_take) begin
      s_next.tbemp = 1'b1;
    end
    if (dp_evt.rx_read) begin
      s_next.rx_buffer_full_flag = 1'b0;
    end
    if (dp_evt.rx_done) begin
      s_next.rx_buffer_full_flag = 1'b1;
    end
    s_next.txrun = dp_evt.tx_active;

    // Error flags are sticky until a soft reset
    s_next.overrun_error_flag = s_reg.overrun_error_flag | dp_evt.overrun;
    s_next.parity_error_flag = s_reg.parity_error_flag | dp_evt.parity;
    s_next.framing_error_flag = s_reg.framing_error_flag | dp_evt.framing;

    // Soft reset clears enables and flags; a transfer caught mid-flight may
    // set a flag again, which is why software repeats the sequence
    if (srst_apply) begin
      s_next.rx_en = 1'b0;
      s_next.tx_en = 1'b0;
      s_next.tbemp = 1'b0;
      s_next.rx_buffer_full_flag = 1'b0;
      s_next.txrun = 1'b0;
      s_next.overrun_error_flag = 1'b0;
      s_next.parity_error_flag = 1'b0;
      s_next.framing_error_flag = 1'b0;
    end

    // Sticky status: new events win over a clear written this cycle
    s_next.ist = s_next.ist | evt;
  end

  // ****************************************************************************
  // State register
  // ****************************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.sr <= SBSR_SR_IDLE;
      s_reg.brcr <= SBSR_BRCR_RST;
      s_reg.brk <= SBSR_BRK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign hreadyout = !(s_reg.dp_valid && !s_reg.dp_write && !s_reg.rd_done);
  assign hrdata = s_reg.rdata;
  assign hresp = 1'b0;
  assign irq = |(s_reg.ist & s_reg.ien);

  // Double buffering: transmit follows the select bit in every mode
  always_comb begin
    cfg.rx_enable = s_reg.rx_en;
    cfg.tx_enable = s_reg.tx_en;
    cfg.tx_dbuf_en = s_reg.wbuf;
    // Receive buffering is forced on whenever the far end clocks the data
    cfg.rx_dbuf_en = s_reg.uart_mode || s_reg.sclk_in || s_reg.wbuf;
    cfg.uart_mode = s_reg.uart_mode;
    cfg.sclk_input = s_reg.sclk_in;
    cfg.chan_reset = srst_apply;
  end

  // ****************************************************************************
  // Baud clock
  // ****************************************************************************
  sbsr_prescaler u_pre (
    .clk(clk),
    .nrst(nrst),
    .taps(taps)
  );

  // Fraction works only in UART mode; the enable is ignored otherwise
  sbsr_baud_gen u_bg (
    .clk(clk),
    .nrst(nrst),
    .taps(taps),
    .tap_sel(s_reg.brcr[5:4]),
    .n_code(s_reg.brcr[3:0]),
    .k_code(s_reg.brk),
    .frac_en(s_reg.brcr[SBSR_BR_FRAC] && s_reg.uart_mode),
    .tick(baud_tick)
  );

  // ****************************************************************************
  // Assertions
  // ****************************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  srst_delay_a: assert property (
    srst_start |=> !srst_apply ##1 srst_apply ##1 (!s_reg.rx_en && !s_reg.tx_en))
    else $error("soft reset not applied two clocks after recognition");

  srst_armed_a: assert property (
    srst_start |-> s_reg.sr == SBSR_SR_ARMED && $past(s_reg.sr) == SBSR_SR_ARMED)
    else $error("soft reset fired without a preceding arm write");

  srst_fire_a: assert property (
    wr && s_reg.dp_addr == SBSR_OFS_MODE2 && hwdata[1:0] == SBSR_SRST_FIRE
      && s_reg.sr == SBSR_SR_ARMED |-> ##2 srst_apply)
    else $error("fire code after arm did not start a soft reset");

  srst_flags_a: assert property (
    srst_apply |=> !(s_reg.tbemp | s_reg.rx_buffer_full_flag | s_reg.txrun | s_reg.overrun_error_flag
      | s_reg.parity_error_flag | s_reg.framing_error_flag))
    else $error("soft reset left a flag set");

  txrun_track_a: assert property (
    !srst_apply |=> s_reg.txrun == $past(dp_evt.tx_active))
    else $error("transmitting flag does not follow the datapath");

  tx_dbuf_a: assert property (
    wr && s_reg.dp_addr == SBSR_OFS_MODE2 |=> cfg.tx_dbuf_en == $past(hwdata[SBSR_M2_WBUF]))
    else $error("transmit double buffer does not follow the select bit");

  rx_dbuf_a: assert property (
    s_reg.uart_mode || s_reg.sclk_in |-> cfg.rx_dbuf_en)
    else $error("receive double buffer off in a forced mode");

  irq_event_a: assert property (
    dp_evt.framing && s_reg.ien[SBSR_EVT_FRAMING_ERROR_FLAG] |=> irq [*2])
    else $error("enabled framing event did not hold the interrupt");

  read_wait_a: assert property (
    addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not complete after one wait state");

  srst_seq_c: cover property (srst_start ##2 srst_apply);
  irq_c: cover property ($rose(irq));
  rd_err_c: cover property (s_reg.overrun_error_flag && s_reg.parity_error_flag && s_reg.framing_error_flag);
  dbuf_force_c: cover property (!s_reg.wbuf && cfg.rx_dbuf_en);

endmodule // sbsr_top

// *** sim/sbsr_far_model.sv ***
// Far-side model: stand-in for the shift-register datapath and the remote serial device
`timescale 1ns/1ps
module sbsr_far_model import sbsr_pkg::*; #(
  parameter int TX_BITS = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire sbsr_cfg_t cfg,
  input wire logic baud_tick,
  input wire logic tx_req,
  input wire logic [4:0] ev_req,
  output sbsr_dp_evt_t dp_evt
);
  logic load_reg;
  logic take_reg;
  logic [4:0] ev_reg;
  int bits_reg;

  // ****************************************************************************
  // Frame timing and event pulses
  // ****************************************************************************
  // A frame lasts TX_BITS baud ticks; a channel reset cuts it short like the real shifter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      load_reg <= 1'b0;
      take_reg <= 1'b0;
      ev_reg <= 5'h00;
      bits_reg <= 0;
    end else begin
      load_reg <= tx_req;
      take_reg <= load_reg;
      ev_reg <= ev_req;
      if (cfg.chan_reset) begin
        bits_reg <= 0;
      end else if (tx_req) begin
        bits_reg <= TX_BITS;
      end else if (baud_tick && bits_reg > 0) begin
        bits_reg <= bits_reg - 1;
      end
    end
  end

  // Events are one-cycle pulses; the busy level follows the frame count
  assign dp_evt = {load_reg, take_reg, bits_reg != 0, ev_reg};
endmodule // sbsr_far_model

// *** sim/tb.sv ***
// Testbench: bus tasks, far-side model and self-checking scenarios of the baud block
`timescale 1ns/1ps
module tb import sbsr_pkg::*;;
  localparam logic [7:0] OFS [7] = '{SBSR_OFS_CHAN, SBSR_OFS_MODE2, SBSR_OFS_ERR,
    SBSR_OFS_BRCR, SBSR_OFS_BRADD, SBSR_OFS_IST, 8'h20};
  logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, baud_tick, irq, tx_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] ev_req;
  sbsr_dp_evt_t dp_evt;
  sbsr_cfg_t cfg;
  int bad_count, checks, n, k, s, d, sum;

  assign hready = hreadyout;

  sbsr_top u_sbsr_top (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dp_evt(dp_evt), .cfg(cfg), .baud_tick(baud_tick),
    .irq(irq));

  sbsr_far_model u_sbsr_far_model (.clk(clk), .nrst(nrst), .cfg(cfg), .baud_tick(baud_tick),
    .tx_req(tx_req), .ev_req(ev_req), .dp_evt(dp_evt));

  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;

  // ****************************************************************************
  // Tasks
  // ****************************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One single transfer; each phase is held until hready is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge clk); t++; end while (hready !== 1'b1 && t < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk); t++; end while (hready !== 1'b1 && t < 100);
    rd = hrdata;
    if (t >= 100) bad_count++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Datapath stand-in: one-cycle request pulses to the far-side model
  task automatic pulse(input logic tx, input logic [4:0] ev);
    @(posedge clk);
    tx_req <= tx;
    ev_req <= ev;
    @(posedge clk);
    tx_req <= 1'b0;
    ev_req <= 5'h00;
  endtask

  // Arm then fire, then watch the two-clock delay of the channel reset
  task automatic srst();
    wr(SBSR_OFS_MODE2, 32'h5);
    wr(SBSR_OFS_MODE2, 32'h6);
    #1 chk(cfg.chan_reset, 1'b0);
    @(posedge clk); #1 chk(cfg.chan_reset, 1'b1);
    @(posedge clk); #1 chk(cfg.chan_reset, 1'b0);
    chk(cfg.tx_enable, 1'b0);
  endtask

  // Measures tick spacing; the first two spans are dropped as they follow a reprogramming
  task automatic span(input int cnt, input int lo, input int hi, output int total);
    int c;
    total = 0;
    for (int p = -2; p < cnt; p++) begin
      c = 0;
      do begin @(negedge clk); c++; end while (baud_tick !== 1'b1 && c < 5000);
      if (p >= 0) begin
        total += c;
        chk(c == lo || c == hi, 1'b1);
      end
    end
  endtask

  function automatic int nv(input int c);
    return (c == 0) ? 16 : c;
  endfunction

  // Watchdog sized well above the longest baud sweep
  initial begin
    #300000;
    bad_count++;
    results();
  end

  // ****************************************************************************
  // Scenarios
  // ****************************************************************************
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {hsel, hwrite, tx_req} = 3'b000;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    ev_req = 5'h00;
    bad_count = 0;
    checks = 0;
    void'($urandom(10415));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    foreach (OFS[i]) rdc(OFS[i], 32'h0);
    // Every mode and clock direction against the buffer select
    for (int i = 0; i < 8; i++) begin
      wr(SBSR_OFS_CHAN, {28'h0, i[1], i[0], 2'b11});
      wr(SBSR_OFS_MODE2, {29'h0, i[2], 2'b00});
      #1 chk(cfg.tx_dbuf_en, i[2]);
      chk(cfg.rx_dbuf_en, i[2] | i[1] | i[0]);
    end
    // Flags, error bits and a masked then enabled interrupt
    wr(SBSR_OFS_IEN, 32'h0);
    pulse(1'b1, 5'b10111);
    bus(1'b0, SBSR_OFS_MODE2, 32'h0);
    chk(rd & 32'h64, 32'h64);
    rdc(SBSR_OFS_ERR, 32'h7);
    rdc(SBSR_OFS_IST, 32'he);
    chk(irq, 1'b0);
    wr(SBSR_OFS_IEN, 32'h2);
    #1 chk(irq, 1'b1);
    wr(SBSR_OFS_ICLR, 32'h2);
    #1 chk(irq, 1'b0);
    rdc(SBSR_OFS_IST, 32'hc);
    repeat (400) @(posedge clk);
    bus(1'b0, SBSR_OFS_MODE2, 32'h0);
    chk(rd[SBSR_M2_TXRUN], 1'b0);
    // A fire code without a directly preceding arm must not reset
    wr(SBSR_OFS_MODE2, 32'h6);
    repeat (4) @(posedge clk);
    rdc(SBSR_OFS_CHAN, 32'hf);
    wr(SBSR_OFS_MODE2, 32'h5);
    wr(SBSR_OFS_MODE2, 32'h4);
    wr(SBSR_OFS_MODE2, 32'h6);
    repeat (4) @(posedge clk);
    rdc(SBSR_OFS_CHAN, 32'hf);
    // Reset twice in succession, the first while a frame is going out
    pulse(1'b1, 5'b10111);
    bus(1'b0, SBSR_OFS_MODE2, 32'h0);
    chk(rd[SBSR_M2_TXRUN], 1'b1);
    srst();
    srst();
    rdc(SBSR_OFS_CHAN, 32'hc);
    bus(1'b0, SBSR_OFS_MODE2, 32'h0);
    chk(rd & 32'he0, 32'h0);
    rdc(SBSR_OFS_ERR, 32'h0);
    wr(SBSR_OFS_IEN, 32'h1);
    #1 chk(irq, 1'b1);
    wr(SBSR_OFS_ICLR, 32'h1);
    #1 chk(irq, 1'b0);
    // Integer division over every tap, with the divisor boundaries in I/O mode
    wr(SBSR_OFS_CHAN, 32'h3);
    wr(SBSR_OFS_MODE2, 32'h4);
    for (int i = 0; i < 6; i++) begin
      s = i % 4;
      n = (i == 4) ? 0 : (i == 5) ? 1 : $urandom_range(15);
      d = 1 << (2 * s);
      wr(SBSR_OFS_BRCR, {26'h0, s[1:0], n[3:0]});
      span(3, nv(n) * d, nv(n) * d, sum);
      chk(sum, 3 * nv(n) * d);
    end
    // Fractional division in UART mode, K written before the enable
    wr(SBSR_OFS_CHAN, 32'h7);
    for (int j = 0; j < 3; j++) begin
      k = (j == 0) ? 15 : (j == 1) ? 1 : $urandom_range(15, 1);
      n = $urandom_range(15, 2);
      s = $urandom_range(1);
      d = 1 << (2 * s);
      wr(SBSR_OFS_BRCR, 32'h0);
      wr(SBSR_OFS_BRADD, k);
      wr(SBSR_OFS_BRCR, {25'h0, 1'b1, s[1:0], n[3:0]});
      span(16, n * d, (n + 1) * d, sum);
      chk(sum, 16 * n * d + (16 - k) * d);
    end
    // The fraction enable has no effect outside UART mode
    wr(SBSR_OFS_CHAN, 32'h3);
    span(3, n * d, n * d, sum);
    chk(sum, 3 * n * d);
    chk(hresp, 1'b0);
    results();
  end
endmodule // tb
